/* conv_ctrl.sv */
// Converter control: registers, GPIO, sequencer, averager, comparator.
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
// Function
// (R01) Reset makes all eight channels analog
// (R02) Function, direction, drive bits select pin mode
// (R03) Digital outputs drive the written level
// (R04) Input register returns real pin levels; the code reads analog channels as 0
// (R05) Codes are 12-bit unsigned straight binary
// (R06) Codes span 000 to FFF, midscale 800
// (R07) Setting calibration bit starts offset calibration
// (R08) Calibration bit self-clears when calibration ends
// (R09) Three-bit ratio sets averaging for all
// (R10) Averaged result is sixteen bits wide
// (R11) Host starts first conversion, rest internal
// (R12) Averaging lasts sample period times count
// (R13) Result readable only after averaging completes
// (R14) Autonomous mode averages enabled channels in turn
// (R15) Comparator uses top twelve result bits
// (R16) Sampling switch opens during conversion
// (R17) Window comparator flags threshold crossings
// (R18) Manual, autonomous and turbo modes exist
// (R19) Internal rate from oscillator pick and divider
// (R20) Output level ignored on non-output channels
// (R21) Sum samples, scale average to sixteen bits
module conv_ctrl
    import conv_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic track_gate,
    output logic conv_start,
    output logic [2:0] conv_chan,
    input wire logic [11:0] conv_code,
    input wire logic conv_done,
    output logic cal_start,
    input wire logic cal_done,
    output logic threshold_alert
);

    // All block state in one record.
    typedef struct packed {
        seq_state_t st;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic cal;
        logic start;
        mode_t mode;
        logic [7:0] func;
        logic [7:0] dir;
        logic [7:0] drive;
        logic [7:0] olvl;
        logic [2:0] average_ratio;
        logic osc;
        logic [3:0] div;
        logic [7:0] seq_en;
        logic [2:0] man_ch;
        logic [11:0] hi;
        logic [11:0] lo;
        logic [7:0] flags;
        logic [15:0] result;
        logic [2:0] res_ch;
        logic res_valid;
        logic [2:0] chan;
        logic [7:0] cnt;
        logic [18:0] acc;
        logic [23:0] tmr;
        logic [5:0] acq;
        logic cstart;
        logic cal_go;
    } state_t;

    state_t q; // Registered state.
    state_t d; // Next state.
    logic [7:0] flag_set; // Comparator hits this cycle.
    logic [7:0] flag_clr; // Software write-one-to-clear mask.
    logic [18:0] sum; // Accumulator including the arriving code.
    logic [11:0] avg_top; // Upper twelve bits of the new average.
    logic [15:0] avg; // Scaled average.

    // Sample period in clocks: odd dividers are 1.5x, slow oscillator 32x.
    function automatic logic [23:0] period_cyc(input logic osc,
                                               input logic [3:0] div);
        logic [23:0] p;
        p = div[0] ? ODD_CYC : BASE_CYC;
        p = p << div[3:1];
        if (osc) begin
            p = p << SLOW_SHIFT;
        end
        return p;
    endfunction

    // Index of the last sample for a given ratio; zero means no averaging.
    function automatic logic [7:0] last_sample(input logic [2:0] r);
        return 8'((9'h001 << r) - 9'h001);
    endfunction

    // Next enabled channel after cur, wrapping round.
    function automatic logic [2:0] next_chan(input logic [7:0] en,
                                             input logic [2:0] cur);
        logic [2:0] n;
        logic [2:0] pick;
        logic found;
        pick = cur;
        found = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            n = 3'(cur + 3'(i));
            if (!found && en[n]) begin
                pick = n;
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    // Pins actually driven: output channels only, open-drain only pulls low.
    generate
        for (genvar g = 0; g < 8; g++) begin : g_pin
            always_comb begin
                pin_oe[g] = q.func[g] && q.dir[g]
                    && (q.drive[g] || !q.olvl[g]); // R02 R20
                pin_out[g] = q.drive[g] && q.olvl[g]; // R03
            end
        end
    endgenerate

    // Bus and converter outputs: ready and response fixed, the rest from the record.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign conv_start = q.cstart;
    assign cal_start = q.cal_go;
    assign conv_chan = q.chan;
    assign track_gate = (q.st == ST_IDLE) || (q.st == ST_TRACK); // R16
    assign threshold_alert = |q.flags; // R17

    // Averager datapath: sum of 12-bit codes scaled up to 16 bits.
    assign sum = q.acc + {7'h00, conv_code}; // R05 R21
    assign avg = 16'({sum, 4'h0} >> q.average_ratio); // R10 R21
    assign avg_top = avg[15:4]; // R15

    // Next-state logic: sequencer, averager, then bus.
    always_comb begin
        d = q;
        d.cstart = 1'b0;
        d.cal_go = 1'b0;
        flag_set = 8'h00;
        flag_clr = 8'h00;
        // The period timer counts down to the next permitted start.
        if (q.tmr != 24'h000000) begin
            d.tmr = q.tmr - 24'h000001; // R12 R19
        end
        case (q.st)
            ST_IDLE: begin
                if (q.cal) begin
                    d.cal_go = 1'b1; // R07
                    d.st = ST_CAL;
                end else if (q.start || (q.mode == MODE_TURBO)
                        || (q.mode == MODE_AUTO && q.seq_en != 8'h00)) begin
                    // Host starts only the first sample of an average.
                    d.start = 1'b0; // R11 R18
                    d.chan = (q.mode == MODE_SEQ || q.mode == MODE_AUTO)
                        ? next_chan(q.seq_en, q.chan) : q.man_ch; // R14
                    d.cnt = 8'h00;
                    d.acc = 19'h00000;
                    d.acq = 6'h00;
                    d.res_valid = 1'b0; // R13
                    d.st = ST_TRACK;
                end
            end
            ST_TRACK: begin
                // Acquire at least the minimum time, then wait for the period timer to run out.
                if (q.acq < ACQ_CYC - 6'h01) begin
                    d.acq = q.acq + 6'h01;
                end else if (q.tmr == 24'h000000) begin
                    d.cstart = 1'b1; // R16
                    d.tmr = period_cyc(q.osc, q.div) - 24'h000001; // R19
                    d.st = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    d.acc = sum;
                    if (q.cnt == last_sample(q.average_ratio)) begin
                        d.result = avg; // R09 R13
                        d.res_ch = q.chan;
                        d.res_valid = 1'b1; // R13
                        if (avg_top > q.hi || avg_top < q.lo) begin
                            flag_set[q.chan] = 1'b1; // R15 R17
                        end
                        d.st = ST_IDLE;
                    end else begin
                        // Further samples are started internally.
                        d.cnt = q.cnt + 8'h01; // R11 R12
                        d.acq = 6'h00;
                        d.st = ST_TRACK;
                    end
                end
            end
            ST_CAL: begin
                if (cal_done) begin
                    d.cal = 1'b0; // R08
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        // Data phase of a write: applied from the captured address.
        if (q.wr_pend) begin
            case (q.wr_addr)
                GEN_CFG_OFS: begin
                    // A one sets the trigger; a zero never cancels it.
                    d.cal = d.cal | hwdata[CAL_BIT]; // R07
                    d.start = d.start | hwdata[START_BIT];
                    d.mode = mode_t'(hwdata[MODE_LSB +: 2]); // R18
                end
                FUNC_OFS: d.func = hwdata[7:0]; // R02
                DIR_OFS: d.dir = hwdata[7:0]; // R02
                DRIVE_OFS: d.drive = hwdata[7:0]; // R02
                OUT_LVL_OFS: d.olvl = hwdata[7:0]; // R03
                AVG_OFS: d.average_ratio = hwdata[2:0]; // R09
                CLK_OFS: begin
                    d.div = hwdata[3:0]; // R19
                    d.osc = hwdata[OSC_BIT]; // R19
                end
                SEQ_OFS: d.seq_en = hwdata[7:0]; // R14
                MAN_CH_OFS: d.man_ch = hwdata[2:0];
                HI_OFS: d.hi = hwdata[11:0];
                LO_OFS: d.lo = hwdata[11:0];
                STATUS_OFS: flag_clr = hwdata[7:0];
                default: begin
                end
            endcase
        end
        // A comparator hit in the clearing cycle survives the clear.
        d.flags = (q.flags & ~flag_clr) | flag_set;
        // Address phase: capture writes, fetch read data for the data phase.
        d.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            d.wr_pend = hwrite && (hsize == 3'b010);
            d.wr_addr = haddr[7:0];
            d.rdata = 32'h00000000;
            if (!hwrite) begin
                case (haddr[7:0])
                    GEN_CFG_OFS: begin
                        d.rdata[CAL_BIT] = q.cal; // R08
                        d.rdata[MODE_LSB +: 2] = q.mode;
                    end
                    FUNC_OFS: d.rdata[7:0] = q.func;
                    DIR_OFS: d.rdata[7:0] = q.dir;
                    DRIVE_OFS: d.rdata[7:0] = q.drive;
                    OUT_LVL_OFS: d.rdata[7:0] = q.olvl;
                    IN_LVL_OFS: d.rdata[7:0] = pin_in & q.func; // R04
                    AVG_OFS: d.rdata[2:0] = q.average_ratio;
                    CLK_OFS: d.rdata[4:0] = {q.osc, q.div};
                    SEQ_OFS: d.rdata[7:0] = q.seq_en;
                    MAN_CH_OFS: d.rdata[2:0] = q.man_ch;
                    RESULT_OFS: begin
                        d.rdata[15:0] = q.result; // R06 R13
                        d.rdata[RES_CH_LSB +: 3] = q.res_ch;
                    end
                    HI_OFS: d.rdata[11:0] = q.hi;
                    LO_OFS: d.rdata[11:0] = q.lo;
                    STATUS_OFS: begin
                        d.rdata[7:0] = q.flags;
                        d.rdata[BUSY_BIT] = q.st != ST_IDLE;
                        d.rdata[VALID_BIT] = q.res_valid;
                    end
                    default: d.rdata = 32'h00000000;
                endcase
            end
        end
    end

    // State register; every channel comes out of reset analog.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.func <= FUNC_RST; // R01
            q.dir <= GPIO_RST;
            q.drive <= GPIO_RST;
            q.hi <= HI_RST;
            q.lo <= LO_RST;
        end else begin
            q <= d;
        end
    end

    // Checks sample at the bus clock and rest while reset is held.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Once the switch closes for a new sample it stays closed a while.
    sequence acq_s;
        track_gate [*8];
    endsequence

    // The last code of an average arrives in this cycle.
    sequence last_code_s;
        q.st == ST_CONV && conv_done
        && q.cnt == last_sample(q.average_ratio);
    endsequence

    pin_config_a: assert property (pin_oe[0] |-> q.func[0] && q.dir[0])
        else $error("pin driven while not a digital output"); // R02
    push_pull_a: assert property (
        q.func[1] && q.dir[1] && q.drive[1] |-> pin_oe[1]
        && pin_out[1] == q.olvl[1])
        else $error("push-pull output not at written level"); // R03
    analog_quiet_a: assert property (!q.func[2] |-> !pin_oe[2])
        else $error("analog channel drives its pin"); // R20
    switch_open_a: assert property (conv_start |=> !track_gate)
        else $error("sampling switch closed in conversion"); // R16
    acq_before_a: assert property ( // R16
        conv_start |-> $past(track_gate) && q.acq == ACQ_CYC - 6'h01)
        else $error("conversion started without acquisition");
    // The start pulse and the open switch share one cycle, so the
    // acquisition is checked from the closing edge of the switch.
    acq_hold_a: assert property ( // R16
        $rose(track_gate) && q.st == ST_TRACK |-> acq_s)
        else $error("sampling switch reopened during acquisition");
    cal_clear_a: assert property (
        q.st == ST_CAL && cal_done |=> !q.cal && q.st == ST_IDLE)
        else $error("calibration bit not cleared"); // R08
    cal_start_a: assert property (cal_start |-> $past(q.cal))
        else $error("calibration started without trigger"); // R07
    result_late_a: assert property (
        $rose(q.res_valid) |-> $past(q.cnt) == last_sample(q.average_ratio))
        else $error("result valid before averaging done"); // R13
    flag_hold_a: assert property (
        q.st == ST_CONV && conv_done && q.cnt == last_sample(q.average_ratio)
        && avg_top > q.hi |=> q.flags[$past(q.chan)])
        else $error("threshold crossing not flagged"); // R17
    period_gap_a: assert property (
        conv_start |=> !conv_start [*8])
        else $error("conversions closer than one period"); // R12

    // An open-drain output may only pull its pin low.
    open_drain_a: assert property ( // R02
        q.func[6] && q.dir[6] && !q.drive[6] |-> !pin_out[6])
        else $error("open-drain output driven high");
    // A result under the low threshold raises that channel's flag.
    flag_low_a: assert property ( // R17
        last_code_s ##0 (avg_top < q.lo) |=> q.flags[$past(q.chan)])
        else $error("low threshold crossing not flagged");
    // A write of one clears a flag unless a new hit lands in that cycle.
    flag_clear_a: assert property ( // R17
        q.wr_pend && q.wr_addr == STATUS_OFS && hwdata[3] && !flag_set[3]
        |=> !q.flags[3])
        else $error("alert flag not cleared by software");
    // A waiting trigger starts calibration from idle in the next cycle.
    cal_go_a: assert property ( // R07
        q.st == ST_IDLE && q.cal |=> cal_start && q.st == ST_CAL)
        else $error("calibration trigger not acted on");
    // The result only changes when a finished average lands in it.
    result_hold_a: assert property ( // R13
        !$stable(q.result) |-> $rose(q.res_valid))
        else $error("result changed outside average completion");

endmodule // conv_ctrl
`default_nettype wire

/* conv_ctrl_pkg.sv */
// Constants and types shared by the converter control block.
`default_nettype none
package conv_ctrl_pkg;
    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] GEN_CFG_OFS = 8'h00;
    localparam logic [7:0] FUNC_OFS = 8'h04;
    localparam logic [7:0] DIR_OFS = 8'h08;
    localparam logic [7:0] DRIVE_OFS = 8'h0C;
    localparam logic [7:0] OUT_LVL_OFS = 8'h10;
    localparam logic [7:0] IN_LVL_OFS = 8'h14;
    localparam logic [7:0] AVG_OFS = 8'h18;
    localparam logic [7:0] CLK_OFS = 8'h1C;
    localparam logic [7:0] SEQ_OFS = 8'h20;
    localparam logic [7:0] MAN_CH_OFS = 8'h24;
    localparam logic [7:0] RESULT_OFS = 8'h28;
    localparam logic [7:0] HI_OFS = 8'h2C;
    localparam logic [7:0] LO_OFS = 8'h30;
    localparam logic [7:0] STATUS_OFS = 8'h34;
    // Field positions.
    localparam int CAL_BIT = 0;
    localparam int START_BIT = 1;
    localparam int MODE_LSB = 2;
    localparam int OSC_BIT = 4;
    localparam int BUSY_BIT = 8;
    localparam int VALID_BIT = 9;
    localparam int RES_CH_LSB = 16;
    // Reset values.
    localparam logic [7:0] FUNC_RST = 8'h00;
    localparam logic [7:0] GPIO_RST = 8'h00;
    localparam logic [11:0] HI_RST = 12'hFFF;
    localparam logic [11:0] LO_RST = 12'h000;
    // Timing at a 10 ns clock.
    localparam int CLK_NS = 10;
    localparam int CYCLE_FAST_NS = 1000;
    localparam int ACQ_NS = 300;
    localparam logic [23:0] BASE_CYC = 24'(CYCLE_FAST_NS / CLK_NS);
    localparam logic [23:0] ODD_CYC = 24'((CYCLE_FAST_NS * 3) / (2 * CLK_NS));
    localparam logic [5:0] ACQ_CYC = 6'((ACQ_NS + CLK_NS - 1) / CLK_NS);
    localparam int SLOW_SHIFT = 5;
    // Conversion modes.
    typedef enum logic [1:0] {
        MODE_MANUAL = 2'b00,
        MODE_SEQ = 2'b01,
        MODE_AUTO = 2'b10,
        MODE_TURBO = 2'b11
    } mode_t;
    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONV = 2'b10,
        ST_CAL = 2'b11
    } seq_state_t;
endpackage
`default_nettype wire

/* conv_model.sv */
// Behavioural converter that answers start pulses with codes.
`default_nettype none
module conv_model #(
    parameter int DLY = 10
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic conv_start,
    input wire logic cal_start,
    input wire logic [11:0] code_set,
    output logic conv_done,
    output logic [11:0] conv_code,
    output logic cal_done
);
    int cnv_q; // Cycles left until a code is ready, zero when idle.
    int cal_q; // Cycles left until calibration ends, zero when idle.
    // Each start arms a countdown; the answer is a one-cycle pulse.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnv_q <= 0;
            cal_q <= 0;
            conv_done <= 1'b0;
            cal_done <= 1'b0;
            conv_code <= 12'h000;
        end else begin
            conv_done <= (cnv_q == 1);
            cal_done <= (cal_q == 1);
            // The code is only valid with done, so it toggles otherwise.
            conv_code <= (cnv_q == 1) ? code_set : ~conv_code;
            cnv_q <= conv_start ? DLY : ((cnv_q > 0) ? cnv_q - 1 : 0);
            cal_q <= cal_start ? 3 * DLY : ((cal_q > 0) ? cal_q - 1 : 0);
        end
    end
endmodule // conv_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the converter control block.
`default_nettype none
module tb_top import conv_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, conv_chan;
    logic track_gate, conv_start, conv_done, cal_start, cal_done;
    logic threshold_alert;
    logic [7:0] pin_in, pin_out, pin_oe;
    logic [7:0] ext_q; // Level that outside parts put on undriven pins.
    logic [7:0] chan_ok = 8'h08; // Channels a start may legally pick.
    logic tg_prev = 1'b1; // Switch state in the cycle before.
    logic [11:0] conv_code, code_q;
    int miscompares = 0, samples_checked = 0, n_start, n_cal, gap;
    int cyc = 0, last_t = 0;
    // A pin shows our drive where enabled, else the outside level.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_q);
    conv_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .track_gate(track_gate),
        .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_code(conv_code), .conv_done(conv_done),
        .cal_start(cal_start), .cal_done(cal_done),
        .threshold_alert(threshold_alert));
    conv_model u_conv (.hclk(hclk), .hresetn(hresetn),
        .conv_start(conv_start), .cal_start(cal_start), .code_set(code_q),
        .conv_done(conv_done), .conv_code(conv_code), .cal_done(cal_done));
    always #5 hclk = ~hclk;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Watches starts and spacing; the switch must be open at each answer.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        tg_prev <= track_gate;
        if (conv_start) begin
            n_start <= n_start + 1;
            gap <= cyc - last_t;
            last_t <= cyc;
            chk(chan_ok[conv_chan], 32'h1);
            chk(tg_prev, 32'h1);
            chk(track_gate, 32'h0);
        end
        if (cal_start) n_cal <= n_cal + 1;
        if (conv_done) chk(track_gate, 32'h0);
    end
    // Waits for hready at an edge; a bus that never answers ends the run.
    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 20);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            complete_run;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h000000, a};
        hwrite <= 1'b1;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        haddr <= {24'h000000, a};
        hwrite <= 1'b0;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        wait_rdy;
        q = hrdata;
    endtask
    // Reads until the masked field matches, within a bounded count.
    task automatic poll(input logic [7:0] a, input logic [31:0] m, v);
        logic [31:0] q;
        int i;
        i = 0;
        do begin
            rd(a, q);
            i++;
        end while ((q & m) !== v && i < 10000);
        chk(q & m, v);
        if ((q & m) !== v) complete_run;
    endtask
    task automatic t_reset;
        logic [31:0] q;
        rd(FUNC_OFS, q);
        chk(q, 32'h0);
        chk(pin_oe, 32'h0);
        chk(hresp, 32'h0);
        rd(HI_OFS, q);
        chk(q, 32'h0FFF);
        rd(8'h3C, q);
        chk(q, 32'h0);
        $display("test reset done");
    endtask
    // Ch0 analog, ch1-3 inputs, ch4-5 push-pull, ch6-7 open-drain.
    task automatic t_gpio;
        logic [31:0] q;
        wr(FUNC_OFS, 32'hFE);
        wr(DIR_OFS, 32'hF0);
        wr(DRIVE_OFS, 32'h30);
        wr(OUT_LVL_OFS, 32'h5F);
        repeat (3) @(posedge hclk);
        chk(pin_oe, 32'hB0);
        chk(pin_out & pin_oe, 32'h10);
        rd(IN_LVL_OFS, q);
        chk(q, 32'h1A);
        ext_q <= 8'hFF;
        repeat (3) @(posedge hclk);
        rd(IN_LVL_OFS, q);
        chk(q, 32'h5E);
        $display("test gpio done");
    endtask
    task automatic t_cal;
        logic [31:0] q;
        int base;
        base = n_cal;
        wr(GEN_CFG_OFS, 32'h1);
        rd(GEN_CFG_OFS, q);
        chk(q & 32'h1, 32'h1);
        poll(GEN_CFG_OFS, 32'h1, 32'h0);
        chk(n_cal - base, 32'h1);
        $display("test cal done");
    endtask
    // One host start, then the block runs the rest of the samples.
    task automatic run_avg(input logic [2:0] r, input logic [3:0] dv,
        input logic [11:0] c, input logic [15:0] e);
        logic [31:0] q;
        int base;
        wr(AVG_OFS, {29'h0, r});
        wr(CLK_OFS, {28'h0, dv});
        wr(MAN_CH_OFS, 32'h3);
        code_q <= c;
        base = n_start;
        wr(GEN_CFG_OFS, 32'h2);
        // Wait for busy first, or the last run's valid bit passes at once.
        poll(STATUS_OFS, 32'h100, 32'h100);
        poll(STATUS_OFS, 32'h300, 32'h200);
        chk(n_start - base, 32'h1 << r);
        rd(RESULT_OFS, q);
        chk(q, {13'h0, 3'h3, e});
        if (r > 0) chk(gap, dv[0] ? 32'd150 : 32'd100);
    endtask
    task automatic t_avg;
        run_avg(3'h0, 4'h0, 12'hFFF, 16'hFFF0);
        run_avg(3'h0, 4'h0, 12'h000, 16'h0000);
        run_avg(3'h2, 4'h0, 12'h800, 16'h8000);
        run_avg(3'h3, 4'h1, 12'h801, 16'h8010);
        run_avg(3'h7, 4'h0, 12'h123, 16'h1230);
        chk(threshold_alert, 32'h0);
        wr(HI_OFS, 32'h122);
        run_avg(3'h2, 4'h0, 12'h123, 16'h1230);
        chk(threshold_alert, 32'h1);
        wr(STATUS_OFS, 32'h8);
        @(posedge hclk);
        chk(threshold_alert, 32'h0);
        wr(HI_OFS, 32'hFFF);
        wr(LO_OFS, 32'h124);
        run_avg(3'h0, 4'h0, 12'h123, 16'h1230);
        chk(threshold_alert, 32'h1);
        $display("test averaging done");
    endtask
    // Host-started sequence, then autonomous and turbo running free.
    task automatic t_auto;
        logic [31:0] q;
        wr(AVG_OFS, 32'h0);
        wr(SEQ_OFS, 32'h24);
        chan_ok <= 8'h24;
        code_q <= 12'h0F0;
        wr(GEN_CFG_OFS, 32'h6);
        poll(STATUS_OFS, 32'h100, 32'h100);
        poll(STATUS_OFS, 32'h300, 32'h200);
        rd(RESULT_OFS, q);
        chk(q, 32'h00050F00);
        wr(GEN_CFG_OFS, 32'h8);
        poll(RESULT_OFS, 32'h7FFFF, 32'h20F00);
        poll(RESULT_OFS, 32'h7FFFF, 32'h50F00);
        // An average already under way may still finish on its channel.
        chan_ok <= 8'h2C;
        wr(GEN_CFG_OFS, 32'hC);
        poll(RESULT_OFS, 32'h7FFFF, 32'h30F00);
        chan_ok <= 8'h08;
        repeat (250) @(posedge hclk);
        $display("test modes done");
    endtask
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b1;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'h2;
        ext_q = 8'h0A;
        code_q = 12'h000;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_gpio;
        t_cal;
        t_avg;
        t_auto;
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
